// ---- rtl/pio_port_cfg.sv ----
// Three byte-wide ports of pin cells with registered configuration.
// Assumes pad inputs are synchronous to ref_clk; no software bus here.
module pio_port_cfg #(
   parameter int unsigned PORTS = pio_pkg::NUM_PORTS,
   parameter int unsigned WIDTH = pio_pkg::PORT_W
) (
   input  wire logic                 ref_clk,
   input  wire logic                 rst,
   input  wire pio_pkg::pio_cfg_t    cfg,
   input  wire logic                 cfg_we,
   input  wire logic [23:0]          pad_in,
   input  wire logic                 dbg_active,
   input  wire logic                 dbg_out,
   input  wire logic                 dbg_oe,
   output pio_pkg::pio_pad_t         pad_ff,
   output logic [23:0]               rd_data_ff,
   output logic                      dbg_in_ff
);

   // ********************************
   // Configuration registers
   // ********************************
   pio_pkg::pio_cfg_t cfg_ff;
   pio_pkg::pio_cfg_t nxt_cfg;
   pio_pkg::pio_cfg_t cfg_eff;
   pio_pkg::pio_pad_t nxt_pad;
   logic [23:0]       nxt_rd;
   logic [23:0]       c_out, c_oe, c_pu, c_rx, c_rd;

   // Reset value of one field replicated over all ports
   function automatic logic [23:0] rep(input logic [7:0] v);
      rep = {v, v, v};
   endfunction : rep

   // Next configuration: load on write, defaults after reset
   always_comb begin
      nxt_cfg = cfg_ff;
      if (rst) begin
         nxt_cfg.mode_sel  = rep(pio_pkg::RST_MODE_SEL);
         nxt_cfg.drive_sel = rep(pio_pkg::RST_DRIVE_SEL);
         nxt_cfg.out_val   = rep(pio_pkg::RST_OUT_VAL);
         nxt_cfg.pu_dis    = pio_pkg::RST_PU_DIS;
      end else if (cfg_we) begin
         nxt_cfg = cfg;
      end
   end

   always_ff @(posedge ref_clk) begin
      cfg_ff <= nxt_cfg;
   end

   // Withheld pins forced analog; debug pin taken over while active
   always_comb begin
      cfg_eff = cfg_ff;
      cfg_eff.mode_sel = cfg_ff.mode_sel & pio_pkg::PIN_AVAIL_MASK;
      if (dbg_active) begin
         cfg_eff.mode_sel[pio_pkg::DBG_PIN_IDX]  = 1'b1;
         cfg_eff.drive_sel[pio_pkg::DBG_PIN_IDX] = 1'b1;
         cfg_eff.out_val[pio_pkg::DBG_PIN_IDX]   = dbg_out;
      end
   end

   // ********************************
   // Pin cells
   // ********************************
   for (genvar i = 0; i < PORTS * WIDTH; i++) begin : g_cell
      pio_cell u_cell (
         .mode_dig  (cfg_eff.mode_sel[i]),
         .push_pull (cfg_eff.drive_sel[i]),
         .out_val   (cfg_eff.out_val[i]),
         .pu_dis    (cfg_eff.pu_dis),
         .pad_in    (pad_in[i]),
         .pad_out   (c_out[i]),
         .pad_oe    (c_oe[i]),
         .pull_en   (c_pu[i]),
         .rx_en     (c_rx[i]),
         .rd_val    (c_rd[i])
      );
   end

   // Debug drive enable overrides the cell enable on the shared pin
   always_comb begin
      nxt_pad.out     = c_out;
      nxt_pad.oe      = c_oe;
      nxt_pad.pull_en = c_pu;
      nxt_pad.rx_en   = c_rx;
      if (dbg_active) begin
         nxt_pad.oe[pio_pkg::DBG_PIN_IDX]     = dbg_oe;
         nxt_pad.pull_en[pio_pkg::DBG_PIN_IDX] =
            ~cfg_ff.pu_dis & ~(dbg_oe & ~dbg_out);
      end
      nxt_rd = c_rd;
   end

   // ********************************
   // Output registers
   // ********************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pad_ff.out    <= rep(pio_pkg::RST_OUT_VAL);
         pad_ff.oe     <= '0;
         pad_ff.pull_en <= rep(8'hff) & pio_pkg::PIN_AVAIL_MASK;
         pad_ff.rx_en  <= pio_pkg::PIN_AVAIL_MASK;
         rd_data_ff    <= '0;
         dbg_in_ff     <= 1'b0;
      end else begin
         pad_ff        <= nxt_pad;
         rd_data_ff    <= nxt_rd;
         dbg_in_ff     <= pad_in[pio_pkg::DBG_PIN_IDX];
      end
   end

   // ********************************
   // Checks
   // ********************************
   // Reset leaves every pin released
   reset_state_a: assert property (@(posedge ref_clk)
         rst
         |=> (pad_ff.oe == '0))
      else $error("drive enabled after reset");

   // Reset turns pull-ups and receivers on for offered pins
   reset_pull_a: assert property (@(posedge ref_clk)
         rst
         |=> pad_ff.pull_en == pio_pkg::PIN_AVAIL_MASK
             && pad_ff.rx_en == pio_pkg::PIN_AVAIL_MASK)
      else $error("pull-up or receiver wrong after reset");

   // Analog pin drops pull-up and receiver
   analog_quiet_a: assert property (@(posedge ref_clk)
         disable iff (rst)
         !cfg_eff.mode_sel[0]
         |=> !pad_ff.pull_en[0] && !pad_ff.rx_en[0])
      else $error("analog pin pull-up or receiver on");

   // Analog pin reads zero
   analog_read_a: assert property (@(posedge ref_clk)
         disable iff (rst)
         !cfg_eff.mode_sel[5]
         |=> !rd_data_ff[5])
      else $error("analog pin read nonzero");

   // Push-pull pin drives the output value
   push_pull_a: assert property (@(posedge ref_clk)
         disable iff (rst)
         cfg_eff.mode_sel[1] && cfg_eff.drive_sel[1]
         |=> pad_ff.oe[1] && pad_ff.out[1] == $past(cfg_eff.out_val[1]))
      else $error("push-pull not driving");

   // Open-drain pin drives only a low value
   open_drain_a: assert property (@(posedge ref_clk)
         disable iff (rst)
         cfg_eff.mode_sel[2] && !cfg_eff.drive_sel[2]
         |=> pad_ff.oe[2] == !$past(cfg_eff.out_val[2]))
      else $error("open-drain enable wrong");

   // Released digital pin keeps its pull-up unless pu_dis is set
   hiz_pullup_a: assert property (@(posedge ref_clk)
         disable iff (rst)
         cfg_eff.mode_sel[6] && !cfg_eff.pu_dis && c_oe[6] == 1'b0
         |=> pad_ff.pull_en[6])
      else $error("released pin lacks pull-up");

   // No pull-up while the pin drives low
   low_pullup_a: assert property (@(posedge ref_clk)
         disable iff (rst)
         pad_ff.oe[7] && !pad_ff.out[7]
         |-> !pad_ff.pull_en[7])
      else $error("pull-up on while driving low");

   // Same on every pin, the debug-owned one included
   all_low_a: assert property (@(posedge ref_clk)
         disable iff (rst)
         (pad_ff.oe & ~pad_ff.out & pad_ff.pull_en) == '0)
      else $error("pull-up on while some pin drives low");

   // Global disable clears every pull-up
   global_dis_a: assert property (@(posedge ref_clk)
         disable iff (rst)
         cfg_ff.pu_dis
         |=> pad_ff.pull_en == '0)
      else $error("pull-up on under global disable");

   // Digital pin reads the pad level
   read_pad_a: assert property (@(posedge ref_clk)
         disable iff (rst)
         cfg_eff.mode_sel[3]
         |=> rd_data_ff[3] == $past(pad_in[3]))
      else $error("digital read not pad level");

   // Withheld pins are never driven
   withheld_a: assert property (@(posedge ref_clk)
         disable iff (rst)
         1'b1
         |=> (pad_ff.oe[12:8] == '0))
      else $error("withheld pin driven");

   // Withheld pins keep pull-up and receiver off and read zero
   withheld_quiet_a: assert property (@(posedge ref_clk)
         disable iff (rst)
         1'b1
         |=> pad_ff.pull_en[12:8] == '0 && pad_ff.rx_en[12:8] == '0
             && rd_data_ff[12:8] == '0)
      else $error("withheld pin not quiet");

   // Debug interface owns drive and value of the shared pin
   debug_drive_a: assert property (@(posedge ref_clk)
         disable iff (rst)
         dbg_active
         |=> pad_ff.oe[pio_pkg::DBG_PIN_IDX] == $past(dbg_oe)
             && pad_ff.out[pio_pkg::DBG_PIN_IDX] == $past(dbg_out))
      else $error("debug pin not following debug drive");

   // ********************************
   // Covers
   // ********************************
   // Main scenarios: analog, open-drain low, global disable, debug
   cv_analog: cover property (@(posedge ref_clk) !cfg_ff.mode_sel[0]);
   cv_od_low: cover property (@(posedge ref_clk)
      pad_ff.oe[2] && !cfg_ff.drive_sel[2]);
   cv_pu_dis: cover property (@(posedge ref_clk) cfg_ff.pu_dis);
   cv_dbg:    cover property (@(posedge ref_clk) dbg_active && dbg_oe);
   cv_dbg_rd: cover property (@(posedge ref_clk) dbg_active && !dbg_oe);

endmodule : pio_port_cfg

// ---- include/pio_pkg.sv ----
// Port I/O cell configuration package: widths, reset values, carriers.
// Assumes a single 20 MHz clock and a synchronous active-high reset.
package pio_pkg;

   // ********************************
   // Sizes
   // ********************************
   localparam int unsigned NUM_PORTS = 3;
   localparam int unsigned PORT_W    = 8;
   localparam int unsigned PIN_W     = NUM_PORTS * PORT_W;

   // ********************************
   // Reset values
   // ********************************
   localparam logic [7:0] RST_MODE_SEL  = 8'hff; // Digital after reset
   localparam logic [7:0] RST_DRIVE_SEL = 8'h00; // Open-drain after reset
   localparam logic [7:0] RST_OUT_VAL   = 8'hff; // Latch high: pad released
   localparam logic       RST_PU_DIS    = 1'b0;

   // Pins withheld from users: port 1 bits 0..4 (radio link, bit 3 absent)
   localparam logic [PIN_W-1:0] PIN_AVAIL_MASK = 24'hffe0ff;
   // Debug data pin position: port 2 bit 7
   localparam int unsigned DBG_PIN_IDX = 23;

   // ********************************
   // Carriers
   // ********************************
   typedef struct packed {
      logic [PIN_W-1:0] mode_sel;   // 1 digital, 0 analog
      logic [PIN_W-1:0] drive_sel;  // 1 push-pull, 0 open-drain
      logic [PIN_W-1:0] out_val;    // Output logic value
      logic             pu_dis;     // Global pull-up disable
   } pio_cfg_t;

   typedef struct packed {
      logic [PIN_W-1:0] out;
      logic [PIN_W-1:0] oe;
      logic [PIN_W-1:0] pull_en;    // Weak pull-up on
      logic [PIN_W-1:0] rx_en;
   } pio_pad_t;

endpackage : pio_pkg

// ---- rtl/pio_cell.sv ----
// One port pin cell: combinational pad control and readback.
// Assumes configuration is already registered by the caller.
module pio_cell (
   input  wire logic mode_dig,
   input  wire logic push_pull,
   input  wire logic out_val,
   input  wire logic pu_dis,
   input  wire logic pad_in,
   output logic      pad_out,
   output logic      pad_oe,
   output logic      pull_en,
   output logic      rx_en,
   output logic      rd_val
);

   // ********************************
   // Pad drive and pull-up decision
   // ********************************
   always_comb begin
      pad_out = out_val;
      pad_oe  = mode_dig & (push_pull | ~out_val);
      pull_en = mode_dig & ~pu_dis
                & ~(pad_oe & ~out_val);
      rx_en   = mode_dig;
      rd_val  = mode_dig & pad_in;
   end

endmodule : pio_cell

// ---- testbench/pio_pad_model.sv ----
// Board-side pad model: resolves every pad from the cell, board, pull-up.
// Assumes cell outputs settle before the falling edge of ref_clk.
module pio_pad_model (
   input  wire logic              ref_clk,
   input  wire pio_pkg::pio_pad_t pad,
   input  wire logic [23:0]       ext_en,
   input  wire logic [23:0]       ext_val,
   output logic      [23:0]       pad_in,
   output logic      [23:0]       pad_def
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [23:0] lvl;
   // ************************************
   // Pad resolution
   // ************************************
   // Cell drive wins, then board drive, then weak pull-up
   always_comb begin
      pad_def = pad.oe | ext_en | pad.pull_en;
      lvl = (pad.oe & pad.out) | (~pad.oe & ext_en & ext_val)
          | (~pad.oe & ~ext_en & pad.pull_en);
   end
   // Floating pads show the inverse of their last level
   initial pad_in = 24'h000000;
   always @(negedge ref_clk)
      pad_in <= (lvl & pad_def) | (~pad_in & ~pad_def);
endmodule : pio_pad_model

// ---- testbench/tb.sv ----
// Self-checking bench for the three-port pin cell array.
// Assumes the pad model on the board side; inputs change on falling edges.
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic              ref_clk, rst, cfg_we, dbg_active, dbg_out, dbg_oe;
   logic              dbg_in_ff;
   pio_pkg::pio_cfg_t cfg, cur;
   pio_pkg::pio_pad_t pad_ff;
   logic [23:0]       pad_in, pad_def, rd_data_ff, ext_en, ext_val;
   integer            seed = 32'h2246;
   integer            miscompares = 0;
   integer            checks_done = 0;
   // ************************************
   // Clock, design and board
   // ************************************
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   pio_port_cfg i_pio_port_cfg (.ref_clk(ref_clk), .rst(rst), .cfg(cfg),
      .cfg_we(cfg_we), .pad_in(pad_in), .dbg_active(dbg_active),
      .dbg_out(dbg_out), .dbg_oe(dbg_oe), .pad_ff(pad_ff),
      .rd_data_ff(rd_data_ff), .dbg_in_ff(dbg_in_ff));
   pio_pad_model i_pio_pad_model (.ref_clk(ref_clk), .pad(pad_ff),
      .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in),
      .pad_def(pad_def));
   // ************************************
   // Tasks
   // ************************************
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc
   task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   // Expected pad controls and readback from the bench's copy of cfg
   task automatic check_all;
      logic [23:0] dig, oe, pu, m;
      begin
         dig = cur.mode_sel & pio_pkg::PIN_AVAIL_MASK;
         oe = dig & (cur.drive_sel | ~cur.out_val);
         pu = dig & ~(oe & ~cur.out_val) & {24{~cur.pu_dis}};
         m = ~dig | pad_def;
         cmp(pad_ff.oe, oe);
         cmp(pad_ff.out & oe, cur.out_val & oe);
         cmp(pad_ff.pull_en, pu);
         cmp(pad_ff.rx_en, dig);
         cmp(rd_data_ff & m, dig & pad_in & m);
      end
   endtask : check_all
   task automatic do_reset(input int n);
      rst = 1'b1;
      ext_en = 24'h000000;
      cyc(n);
      rst = 1'b0;
      cur = {24'hffffff, 24'h000000, 24'hffffff, 1'b0};
      cyc(3);
      check_all();
   endtask : do_reset
   task automatic final_report;
      $display("Checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report
   // ************************************
   // Sequence
   // ************************************
   initial begin
      rst = 1'b1;
      cfg = '0;
      cfg_we = 1'b0;
      dbg_active = 1'b0;
      dbg_out = 1'b0;
      dbg_oe = 1'b0;
      ext_val = 24'h000000;
      do_reset(16);
      for (int i = 0; i < 40; i++) begin
         cfg.mode_sel = 24'($random(seed));
         cfg.drive_sel = 24'($random(seed)) & cfg.mode_sel;
         cfg.out_val = 24'($random(seed)) | ~cfg.mode_sel;
         cfg.pu_dis = 1'($random(seed));
         cfg_we = 1'b1;
         cur = cfg;
         cyc(1);
         cfg_we = 1'b0;
         ext_en = 24'($random(seed)) & cfg.mode_sel;
         ext_val = 24'($random(seed));
         cyc(4);
         check_all();
         if (i == 20)
            do_reset(1);
      end
      // Debug interface takes over the shared pin: drive, then listen
      dbg_active = 1'b1;
      for (int v = 0; v < 4; v++) begin
         dbg_out = v[0];
         dbg_oe = ~v[1];
         ext_en[23] = v[1];
         ext_val[23] = v[0];
         cyc(4);
         cmp({23'h0, pad_ff.oe[23]}, {23'h0, ~v[1]});
         cmp({23'h0, pad_ff.out[23]}, {23'h0, v[0]});
         cmp({23'h0, pad_ff.pull_en[23]},
            {23'h0, ~cur.pu_dis & (v[0] | v[1])});
         cmp({23'h0, dbg_in_ff}, {23'h0, v[0]});
      end
      final_report();
   end
   // Watchdog against a hung run
   initial begin
      #(50 * 100000);
      miscompares++;
      final_report();
   end
endmodule : tb
